// [cpu_state_core.sv]
// Processor base state: registers, byte order, reservation, PC and exceptions
//
// Added by the designer: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`include "cpu_state_params.svh"
module cpu_state_core #(
   parameter int          XLEN          = `GPR_WIDTH,
   parameter int          SETS          = 2,
   parameter bit          FIRST_RELEASE = 1'b0,
   parameter bit          TLB_PRESENT   = 1'b1,
   parameter logic [31:0] RESET_PC      = `PC_RESET_VALUE,
   parameter logic [31:0] EXC_VECTOR    = `EXC_VECTOR
) (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // Wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // Byte order strap pin
   input  wire logic                    byte_order_strap,
   // Instruction step from the pipeline
   input  wire cpu_state_pkg::priv_mode_t priv_mode,
   input  wire cpu_state_pkg::step_t    step,
   input  wire logic [XLEN-1:0]         pc_target,
   input  wire logic [XLEN-1:0]         wr_data,
   input  wire logic [XLEN-1:0]         exc_arg,
   input  wire logic                    store_conflict,
   // Register reads
   input  wire logic [4:0]              rd_a_idx,
   input  wire logic [4:0]              rd_b_idx,
   output logic      [XLEN-1:0]         rd_a_data,
   output logic      [XLEN-1:0]         rd_b_data,
   // State outputs
   output logic      [XLEN-1:0]         cur_pc,
   output logic                         instruction_set_select,
   output logic                         memory_byte_order,
   output logic                         access_byte_order,
   output logic                         user_byte_order_swap,
   output logic                         fpr_width_select,
   output logic                         delay_slot_flag,
   output logic                         link_reservation_flag,
   output logic                         sc_result,
   // Exception report
   output cpu_state_pkg::exc_t          exc_o,
   output logic      [XLEN-1:0]         exc_arg_o,
   output logic      [XLEN-1:0]         exc_epc
);
   import cpu_state_pkg::*;

   localparam int SIDX_W = (SETS > 1) ? $clog2(SETS) : 1;

   // Bus handshake
   logic        bus_req;
   logic        bus_wr;
   logic [31:0] rd_mux;

   // Software-visible state
   logic                   swap_byte_order_bit_reg;
   logic                   fpr_width_bit_reg;
   logic [`SET_FIELD_W-1:0] active_set_field_reg;
   logic [XLEN-1:0]        kernel_scratch_one_reg;
   logic [XLEN-1:0]        kernel_scratch_two_reg;

   // Strap capture
   logic       strap_s1_reg;
   logic       strap_s2_reg;
   logic [1:0] settle_reg;
   logic       captured_reg;
   logic       memory_byte_order_reg;

   // Execution state
   logic [XLEN-1:0] pc_reg;
   logic [XLEN-1:0] pc_next;
   logic [XLEN-1:0] pc_seq;
   logic [XLEN-1:0] link_value;
   logic            isa_reg;
   logic            slot_reg;
   logic            link_flag_reg;
   logic            sc_result_reg;
   logic            exc_fire;
   logic            do_step;
   exc_t            exc_reg;
   logic [XLEN-1:0] exc_arg_reg;
   logic [XLEN-1:0] epc_reg;

   // Register file write port
   logic        gpr_we;
   logic [4:0]  gpr_idx;
   logic [XLEN-1:0] gpr_data;
   logic [SIDX_W-1:0] set_sel;

   // Byte-lane merge for 32-bit bus writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      end
      return r;
   endfunction : lane_merge

   //--- Wishbone slave: ack one cycle after request, drop next cycle
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_wr  = bus_req & wb_we_i & wb_ack_o;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= bus_req & ~wb_ack_o;
   end

   always_comb
   begin
      rd_mux = 32'h00000000;
      case (wb_adr_i)
         `REG_CONTROL:
         begin
            rd_mux[`CTL_SWAP_BIT] = swap_byte_order_bit_reg;
            rd_mux[`CTL_FPR_BIT]  = fpr_width_bit_reg;
         end
         `REG_SHADOW:
            rd_mux[`SET_FIELD_W-1:0] = active_set_field_reg;
         `REG_STATUS:
         begin
            rd_mux[`ST_MEM_ORDER] = memory_byte_order_reg;
            rd_mux[`ST_ACC_ORDER] = access_byte_order;
            rd_mux[`ST_LINK_FLAG] = link_flag_reg;
            rd_mux[`ST_ISA]       = isa_reg;
            rd_mux[`ST_SLOT]      = slot_reg;
            rd_mux[`ST_FPR_MODE]  = fpr_width_select;
            rd_mux[`ST_CAPTURED]  = captured_reg;
         end
         `REG_PC:
            rd_mux = pc_reg[31:0];
         `REG_KSCR_ONE:
            rd_mux = kernel_scratch_one_reg[31:0];
         `REG_KSCR_TWO:
            rd_mux = kernel_scratch_two_reg[31:0];
         `REG_EPC:
            rd_mux = epc_reg[31:0];
         `REG_EXC:
         begin
            rd_mux[`EXC_CODE_LO +: 5] = exc_reg.code;
            rd_mux[`EXC_SLOT_BIT]     = exc_reg.in_slot;
         end
         `REG_CONFIG:
         begin
            rd_mux[7:0]                 = `ARCH_MINOR;
            rd_mux[`CFG_RELEASE_LO +: 8] = `ARCH_RELEASE;
            rd_mux[`CFG_TLB_BIT]        = TLB_PRESENT;
            rd_mux[`CFG_KSCR_BIT]       = 1'b1;
            rd_mux[`CFG_WIDE_BIT]       = (XLEN == 64);
            rd_mux[`CFG_FIRST_BIT]      = FIRST_RELEASE;
         end
         default:
            rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         wb_dat_o <= 32'h00000000;
      else if (bus_req && !wb_ack_o && !wb_we_i)
         wb_dat_o <= rd_mux;
   end

   //--- Software-written control
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         swap_byte_order_bit_reg <= 1'b0;
         fpr_width_bit_reg       <= 1'b0;
      end
      else if (bus_wr && wb_adr_i == `REG_CONTROL && wb_sel_i[0])
      begin
         swap_byte_order_bit_reg <= wb_dat_i[`CTL_SWAP_BIT];
         fpr_width_bit_reg       <= wb_dat_i[`CTL_FPR_BIT];
      end
   end

   // Out-of-range set numbers are ignored
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         active_set_field_reg <= '0;
      else if (bus_wr && wb_adr_i == `REG_SHADOW && wb_sel_i[0]
               && wb_dat_i[`SET_FIELD_W-1:0] < SETS)
         active_set_field_reg <= wb_dat_i[`SET_FIELD_W-1:0];
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         kernel_scratch_one_reg <= '0;
         kernel_scratch_two_reg <= '0;
      end
      else if (bus_wr && wb_adr_i == `REG_KSCR_ONE)
         kernel_scratch_one_reg[31:0] <= lane_merge(kernel_scratch_one_reg[31:0],
                                                    wb_dat_i, wb_sel_i);
      else if (bus_wr && wb_adr_i == `REG_KSCR_TWO)
         kernel_scratch_two_reg[31:0] <= lane_merge(kernel_scratch_two_reg[31:0],
                                                    wb_dat_i, wb_sel_i);
   end

   //--- Byte order strap: synchronise, then capture once after reset
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         strap_s1_reg <= 1'b0;
         strap_s2_reg <= 1'b0;
      end
      else
      begin
         strap_s1_reg <= byte_order_strap;
         strap_s2_reg <= strap_s1_reg;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         settle_reg            <= 2'h0;
         captured_reg          <= 1'b0;
         memory_byte_order_reg <= 1'b0;
      end
      else if (!captured_reg)
      begin
         if (settle_reg == `STRAP_SETTLE)
         begin
            memory_byte_order_reg <= strap_s2_reg;
            captured_reg          <= 1'b1;
         end
         else
            settle_reg <= settle_reg + 2'h1;
      end
   end

   assign memory_byte_order    = memory_byte_order_reg;
   assign user_byte_order_swap = swap_byte_order_bit_reg & (priv_mode == MODE_USER);
   assign access_byte_order    = memory_byte_order_reg ^ user_byte_order_swap;

   assign fpr_width_select = FIRST_RELEASE ? 1'b0 : fpr_width_bit_reg;

   //--- Instruction step
   // Steps are held off until the byte order is known
   assign do_step  = step.valid & captured_reg;
   assign exc_fire = do_step & step.exc_raise;

   assign pc_seq = pc_reg + (step.compressed ? XLEN'(`PC_STEP_NARROW)
                                             : XLEN'(`PC_STEP_WIDE));
   // Return past the delay slot, mode bit merged into bit 0
   assign link_value = (pc_seq + (step.compressed ? XLEN'(`PC_STEP_NARROW)
                                                  : XLEN'(`PC_STEP_WIDE)))
                       | XLEN'(isa_reg);

   always_comb
   begin
      if (exc_fire)
         pc_next = XLEN'(EXC_VECTOR);
      else if (step.pc_write)
         pc_next = {pc_target[XLEN-1:1], 1'b0};
      else
         pc_next = pc_seq;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         pc_reg  <= XLEN'(RESET_PC);
         isa_reg <= 1'b0;
      end
      else if (do_step)
      begin
         pc_reg <= pc_next;
         if (exc_fire)
            isa_reg <= 1'b0;
         else if (step.pc_write)
            isa_reg <= pc_target[0];
      end
   end

   // Flag describes the next instruction executed, not its address
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         slot_reg <= 1'b0;
      else if (do_step)
         slot_reg <= step.branch & ~step.exc_raise;
   end

   // Set by linked load wins over any clear in the same step
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         link_flag_reg <= 1'b0;
      else if (do_step && step.ll && !step.exc_raise)
         link_flag_reg <= 1'b1;
      else if (do_step && step.eret)
         link_flag_reg <= 1'b0;
      else if (store_conflict || (do_step && step.sc && !step.exc_raise))
         link_flag_reg <= 1'b0;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         sc_result_reg <= 1'b0;
      else if (do_step && step.sc && !step.exc_raise)
         sc_result_reg <= link_flag_reg & ~store_conflict;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         exc_reg     <= '0;
         exc_arg_reg <= '0;
         epc_reg     <= '0;
      end
      else
      begin
         exc_reg.valid <= exc_fire;
         if (exc_fire)
         begin
            exc_reg.code    <= step.exc_code;
            exc_reg.in_slot <= slot_reg;
            exc_arg_reg     <= exc_arg;
            epc_reg         <= {pc_reg[XLEN-1:1], isa_reg};
         end
      end
   end

   //--- Register file; a faulting step writes nothing
   assign gpr_we   = do_step & ~step.exc_raise & (step.link_write | step.wr_en);
   assign gpr_idx  = step.link_write ? step.link_rd : step.wr_rd;
   assign gpr_data = step.link_write ? link_value : wr_data;
   assign set_sel  = active_set_field_reg[SIDX_W-1:0];

   gpr_bank #(
      .XLEN   (XLEN),
      .SETS   (SETS),
      .SIDX_W (SIDX_W)
   ) u_bank (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .set_sel   (set_sel),
      .wr_en     (gpr_we),
      .wr_idx    (gpr_idx),
      .wr_data   (gpr_data),
      .rd_a_idx  (rd_a_idx),
      .rd_b_idx  (rd_b_idx),
      .rd_a_data (rd_a_data),
      .rd_b_data (rd_b_data)
   );

   assign cur_pc                 = pc_reg;
   assign instruction_set_select = isa_reg;
   assign delay_slot_flag        = slot_reg;
   assign link_reservation_flag  = link_flag_reg;
   assign sc_result              = sc_result_reg;
   assign exc_o                  = exc_reg;
   assign exc_arg_o              = exc_arg_reg;
   assign exc_epc                = epc_reg;

endmodule : cpu_state_core

// [cpu_state_params.svh]
// Constants for the processor state block
`ifndef CPU_STATE_PARAMS_SVH
`define CPU_STATE_PARAMS_SVH

// Register byte addresses
`define REG_CONTROL     8'h00
`define REG_SHADOW      8'h04
`define REG_STATUS      8'h08
`define REG_PC          8'h0c
`define REG_KSCR_ONE    8'h10
`define REG_KSCR_TWO    8'h14
`define REG_EPC         8'h18
`define REG_EXC         8'h1c
`define REG_CONFIG      8'h20

// Control fields
`define CTL_SWAP_BIT    0
`define CTL_FPR_BIT     1
`define SET_FIELD_W     4

// Status fields
`define ST_MEM_ORDER    0
`define ST_ACC_ORDER    1
`define ST_LINK_FLAG    2
`define ST_ISA          3
`define ST_SLOT         4
`define ST_FPR_MODE     5
`define ST_CAPTURED     6

// Config fields
`define CFG_RELEASE_LO  8
`define CFG_TLB_BIT     16
`define CFG_KSCR_BIT    17
`define CFG_WIDE_BIT    18
`define CFG_FIRST_BIT   19
`define ARCH_RELEASE    8'h05
`define ARCH_MINOR      8'h00

// Exception info fields
`define EXC_CODE_LO     0
`define EXC_SLOT_BIT    8

// Program counter steps and defaults
`define PC_STEP_WIDE    4'h4
`define PC_STEP_NARROW  4'h2
`define PC_RESET_VALUE  32'h00000000
`define EXC_VECTOR      32'h00000100
`define GPR_WIDTH       32
`define GPR_COUNT       32
`define STRAP_SETTLE    2'h3

`endif

// [cpu_state_pkg.sv]
// Types shared by the processor state block
package cpu_state_pkg;

   typedef enum logic [1:0] {
      MODE_KERNEL,
      MODE_SUPERVISOR,
      MODE_USER
   } priv_mode_t;

   typedef struct packed {
      logic       valid;
      logic       compressed;
      logic       branch;
      logic       pc_write;
      logic       link_write;
      logic [4:0] link_rd;
      logic       wr_en;
      logic [4:0] wr_rd;
      logic       ll;
      logic       sc;
      logic       eret;
      logic       exc_raise;
      logic [4:0] exc_code;
   } step_t;

   typedef struct packed {
      logic       valid;
      logic [4:0] code;
      logic       in_slot;
   } exc_t;

endpackage : cpu_state_pkg

// [cpu_state_props.sv]
// Assertion checker for the processor state block
`timescale 1ns/100ps
`include "cpu_state_params.svh"
module cpu_state_props #(
   parameter int XLEN = 32
) (
   // Clock and reset
   input wire logic                       sys_clk,
   input wire logic                       rst,
   // Bus
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_ack_o,
   // Step side
   input wire cpu_state_pkg::priv_mode_t  priv_mode,
   input wire cpu_state_pkg::step_t       step,
   input wire logic                       store_conflict,
   input wire logic [4:0]                 rd_a_idx,
   input wire logic [XLEN-1:0]            rd_a_data,
   // State
   input wire logic [XLEN-1:0]            cur_pc,
   input wire logic                       memory_byte_order,
   input wire logic                       access_byte_order,
   input wire logic                       user_byte_order_swap,
   input wire logic                       delay_slot_flag,
   input wire logic                       link_reservation_flag,
   input wire logic                       sc_result,
   input wire cpu_state_pkg::exc_t        exc_o
);
   import cpu_state_pkg::*;
   logic [2:0] up_cnt;
   logic       run;
   // Steps count only once the byte order is captured
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         up_cnt <= 3'h0;
      else if (up_cnt != 3'h7)
         up_cnt <= up_cnt + 3'h1;
   assign run = (up_cnt == 3'h7) && step.valid && !step.exc_raise;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_zero_read: assert property (rd_a_idx == 5'h0 |-> rd_a_data == '0)
      else $error("register zero not zero");
   a_order_xor: assert property (
      access_byte_order == (memory_byte_order ^ user_byte_order_swap))
      else $error("access order wrong");
   a_swap_user: assert property (user_byte_order_swap |-> priv_mode == MODE_USER)
      else $error("swap outside user mode");
   a_order_fixed: assert property (up_cnt == 3'h7 |-> $stable(memory_byte_order))
      else $error("memory order moved");
   a_ll_set: assert property (run && step.ll |=> link_reservation_flag)
      else $error("reservation not set");
   a_eret_clear: assert property (run && step.eret && !step.ll |=> !link_reservation_flag)
      else $error("reservation kept over return");
   a_sc_test: assert property (run && step.sc && !step.ll |=>
      sc_result == ($past(link_reservation_flag) && !$past(store_conflict)))
      else $error("conditional store result wrong");
   a_pc_advance: assert property (run && !step.pc_write |=>
      cur_pc == $past(cur_pc) + ($past(step.compressed) ? XLEN'(2) : XLEN'(4)))
      else $error("pc step wrong");
   a_slot_track: assert property (run |=> delay_slot_flag == $past(step.branch))
      else $error("slot flag wrong");
   a_exc_stop: assert property (up_cnt == 3'h7 && step.valid && step.exc_raise |=>
      exc_o.valid && cur_pc == XLEN'(`EXC_VECTOR))
      else $error("exception not taken");
   a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one pulse");
   c_ll: cover property (run && step.ll);
   c_sc_ok: cover property (run && step.sc && link_reservation_flag);
   c_exc: cover property (exc_o.valid && exc_o.in_slot);
endmodule : cpu_state_props
bind cpu_state_core cpu_state_props #(.XLEN(XLEN)) u_props (
   .sys_clk               (sys_clk),
   .rst                   (rst),
   .wb_cyc_i              (wb_cyc_i),
   .wb_stb_i              (wb_stb_i),
   .wb_ack_o              (wb_ack_o),
   .priv_mode             (priv_mode),
   .step                  (step),
   .store_conflict        (store_conflict),
   .rd_a_idx              (rd_a_idx),
   .rd_a_data             (rd_a_data),
   .cur_pc                (cur_pc),
   .memory_byte_order     (memory_byte_order),
   .access_byte_order     (access_byte_order),
   .user_byte_order_swap  (user_byte_order_swap),
   .delay_slot_flag       (delay_slot_flag),
   .link_reservation_flag (link_reservation_flag),
   .sc_result             (sc_result),
   .exc_o                 (exc_o)
);

// [gpr_bank.sv]
// Shadowed general register storage with hard-wired zero
`timescale 1ns/100ps
`include "cpu_state_params.svh"
module gpr_bank #(
   parameter int XLEN   = 32,
   parameter int SETS   = 2,
   parameter int SIDX_W = 1
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Set select
   input  wire logic [SIDX_W-1:0] set_sel,
   // Write port
   input  wire logic              wr_en,
   input  wire logic [4:0]        wr_idx,
   input  wire logic [XLEN-1:0]   wr_data,
   // Read ports
   input  wire logic [4:0]        rd_a_idx,
   input  wire logic [4:0]        rd_b_idx,
   output logic      [XLEN-1:0]   rd_a_data,
   output logic      [XLEN-1:0]   rd_b_data
);
   localparam int ENTRIES = SETS * `GPR_COUNT;

   logic [XLEN-1:0] mem [ENTRIES];

   genvar g;
   generate
      for (g = 0; g < ENTRIES; g++)
      begin : g_entry
         if ((g % `GPR_COUNT) == 0)
         begin : g_zero
            assign mem[g] = '0;
         end
         else
         begin : g_flop
            always_ff @(posedge sys_clk or posedge rst)
            begin
               if (rst)
                  mem[g] <= '0;
               else if (wr_en && ({set_sel, wr_idx} == (SIDX_W+5)'(g)))
                  mem[g] <= wr_data;
            end
         end
      end
   endgenerate

   // Register zero reads zero whatever was written
   assign rd_a_data = (rd_a_idx == 5'h00) ? '0 : mem[{set_sel, rd_a_idx}];
   assign rd_b_data = (rd_b_idx == 5'h00) ? '0 : mem[{set_sel, rd_b_idx}];

endmodule : gpr_bank

// [tb_top.sv]
// Self-checking bench for the processor state block
`timescale 1ns/100ps
`include "cpu_state_params.svh"
module tb_top;
   import cpu_state_pkg::*;
   logic        sys_clk = 1'b0, rst = 1'b1, byte_order_strap = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, store_conflict = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = '0, pc_target = '0, wr_data = '0, exc_arg = '0;
   logic [4:0]  rd_a_idx = 5'h0, rd_b_idx = 5'h0, a;
   priv_mode_t  priv_mode = MODE_KERNEL;
   step_t       step = '0;
   logic [31:0] wb_dat_o, rd_a_data, rd_b_data, cur_pc, exc_arg_o, exc_epc;
   logic        wb_ack_o, isa, mem_o, acc_o, swap_o, fpr_o, slot_o, link_o, sc_o;
   exc_t        exc_o;
   int          err_count = 0, n_compared = 0, set = 0;
   integer      seed = 32'h31e6;
   logic [31:0] mdl_gpr [2][32] = '{default: '0};
   logic [31:0] mdl_pc = '0, rdat, v, d;
   logic        strap_v;
   always #10 sys_clk = ~sys_clk;
   cpu_state_core DUT (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .byte_order_strap(byte_order_strap),
      .priv_mode(priv_mode), .step(step), .pc_target(pc_target), .wr_data(wr_data),
      .exc_arg(exc_arg), .store_conflict(store_conflict), .rd_a_idx(rd_a_idx),
      .rd_b_idx(rd_b_idx), .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .cur_pc(cur_pc),
      .instruction_set_select(isa), .memory_byte_order(mem_o), .access_byte_order(acc_o),
      .user_byte_order_swap(swap_o), .fpr_width_select(fpr_o), .delay_slot_flag(slot_o),
      .link_reservation_flag(link_o), .sc_result(sc_o), .exc_o(exc_o),
      .exc_arg_o(exc_arg_o), .exc_epc(exc_epc));
   task automatic final_report;
      if (err_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel);
      int n;
      n = 0;
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge sys_clk);
      end
      chk(wb_ack_o, 1'b1, "ack");
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   // One instruction step, model updated after its edge
   task automatic stp(input step_t s, input logic [31:0] dv);
      @(posedge sys_clk);
      step      <= s;
      wr_data   <= dv;
      pc_target <= dv;
      exc_arg   <= dv;
      @(posedge sys_clk);
      step <= '0;
      #1;
      if (s.exc_raise)
         mdl_pc = `EXC_VECTOR;
      else if (s.pc_write)
         mdl_pc = {dv[31:1], 1'b0};
      else
         mdl_pc += s.compressed ? 2 : 4;
      chk(cur_pc, mdl_pc, "pc");
      if (s.wr_en && !s.exc_raise && !s.link_write && s.wr_rd != 5'h0)
         mdl_gpr[set][s.wr_rd] = dv;
   endtask : stp
   task automatic rdchk(input logic [4:0] ia, input logic [4:0] ib);
      @(posedge sys_clk);
      rd_a_idx <= ia;
      rd_b_idx <= ib;
      #1;
      chk(rd_a_data, mdl_gpr[set][ia], "gpr a");
      chk(rd_b_data, mdl_gpr[set][ib], "gpr b");
   endtask : rdchk
   initial
   begin
      #400000;
      err_count++;
      final_report();
   end
   initial
   begin
      strap_v = $random(seed);
      byte_order_strap = strap_v;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      byte_order_strap <= ~strap_v;
      wb(1'b0, `REG_STATUS, '0, 4'hf);
      chk(rdat, {25'h0, 1'b1, 4'h0, strap_v, strap_v}, "status");
      wb(1'b0, `REG_CONFIG, '0, 4'hf);
      chk(rdat, 32'h0003_0500, "config");
      chk(mem_o, strap_v, "mem order");
      wb(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
      wb(1'b0, 8'h40, '0, 4'hf);
      chk(rdat, '0, "unmapped");
      for (int i = 0; i < 2; i++)
      begin
         v = $random(seed);
         a = (i == 0) ? `REG_KSCR_ONE : `REG_KSCR_TWO;
         wb(1'b1, a, v, 4'hf);
         wb(1'b1, a, 32'h0000_a500, 4'h2);
         wb(1'b0, a, '0, 4'hf);
         chk(rdat, {v[31:16], 8'ha5, v[7:0]}, "scratch");
      end
      for (int c = 0; c < 4; c++)
      begin
         wb(1'b1, `REG_CONTROL, c, 4'h1);
         for (int m = 0; m < 3; m++)
         begin
            @(posedge sys_clk);
            priv_mode <= priv_mode_t'(m);
            @(posedge sys_clk);
            #1;
            chk(swap_o, c[0] && m == 2, "swap");
            chk(acc_o, strap_v ^ (c[0] && m == 2), "acc order");
            chk(fpr_o, c[1], "fpr mode");
         end
      end
      for (int k = 0; k < 24; k++)
      begin
         if (k % 6 == 0)
         begin
            v = $random(seed) & 32'h3;
            wb(1'b1, `REG_SHADOW, v, 4'h1);
            set = (v < 2) ? v : set;
            wb(1'b0, `REG_SHADOW, '0, 4'hf);
            chk(rdat & 32'hf, set, "set");
         end
         a = (k == 0) ? 5'h0 : 5'($random(seed));
         stp('{valid: 1'b1, wr_en: 1'b1, wr_rd: a, compressed: k[0], default: '0}, $random(seed));
         rdchk(a, 5'($random(seed)));
      end
      stp('{valid: 1'b1, ll: 1'b1, default: '0}, '0);
      chk(link_o, 1'b1, "ll");
      for (int j = 0; j < 2; j++)
      begin
         stp('{valid: 1'b1, sc: 1'b1, default: '0}, '0);
         chk({sc_o, link_o}, {j == 0, 1'b0}, "sc");
      end
      stp('{valid: 1'b1, ll: 1'b1, default: '0}, '0);
      @(posedge sys_clk);
      store_conflict <= 1'b1;
      @(posedge sys_clk);
      store_conflict <= 1'b0;
      #1;
      chk(link_o, 1'b0, "conflict");
      stp('{valid: 1'b1, ll: 1'b1, default: '0}, '0);
      stp('{valid: 1'b1, eret: 1'b1, default: '0}, '0);
      chk(link_o, 1'b0, "eret");
      v = mdl_pc + 12;
      stp('{valid: 1'b1, branch: 1'b1, link_write: 1'b1, link_rd: 5'h9, default: '0}, '0);
      chk(slot_o, 1'b1, "slot");
      mdl_gpr[set][9] = v - 4;
      rdchk(5'h9, 5'h0);
      stp('{valid: 1'b1, default: '0}, '0);
      chk(slot_o, 1'b0, "slot");
      stp('{valid: 1'b1, pc_write: 1'b1, default: '0}, 32'h0000_2001);
      chk(isa, 1'b1, "isa");
      v = (mdl_pc + 4) | 32'h1;
      stp('{valid: 1'b1, link_write: 1'b1, link_rd: 5'h9, compressed: 1'b1, default: '0}, '0);
      mdl_gpr[set][9] = v;
      rdchk(5'h9, 5'h0);
      stp('{valid: 1'b1, branch: 1'b1, compressed: 1'b1, default: '0}, '0);
      a = 5'($random(seed));
      d = $random(seed);
      v = mdl_pc;
      stp('{valid: 1'b1, exc_raise: 1'b1, exc_code: a, wr_en: 1'b1, wr_rd: 5'h3,
            ll: 1'b1, default: '0}, d);
      chk({exc_o.valid, exc_o.in_slot, exc_o.code}, {2'b11, a}, "exc");
      chk(exc_arg_o, d, "exc arg");
      chk(exc_epc, v | 32'h1, "epc");
      chk({exc_epc[0], isa, link_o}, 3'b100, "exc state");
      rdchk(5'h3, 5'h0);
      wb(1'b0, `REG_EXC, '0, 4'hf);
      chk(rdat, {23'h0, 1'b1, 3'h0, a}, "exc reg");
      final_report();
   end
endmodule : tb_top
